// [src/sata_port_command_control.sv]
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module sata_port_command_control
  import port_cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cold_presence_detect_in_i,
  input  wire logic        mech_switch_in_i,
  input  wire logic        switch_capability_i,
  input  wire logic        cmd_done_i,
  input  wire logic        frame_valid_i,
  input  wire logic        frame_first_d2h_i,
  output logic             frame_post_o,
  output logic             frame_reject_o,
  output logic             issue_valid_o,
  output logic [4:0]       issue_slot_o,
  output logic             device_power_out_o
);
  logic [31:0]  ctrl_r;
  logic [31:0]  command_issue_reg_r;
  logic [7:0]   task_file_data_r;
  logic [4:0]   current_command_slot_r;
  logic [4:0]   next_prio_r;
  logic         proc_en_d_r;
  logic         first_d2h_done_r;
  logic         cold_presence_state_r;
  logic         cold_seeded_r;
  logic         mech_switch_state_r;
  logic         command_list_running_r;
  logic         frame_receive_running_r;
  logic         found;
  logic [4:0]   pick;
  issue_state_t iss_r;
  logic         acc;
  logic         wr;
  logic [31:0]  be_mask;
  logic [31:0]  cmd_read;
  logic         proc_en;
  logic         cold_support;
  logic         override_set;
  logic [31:0]  ci_clr;
  logic [31:0]  ci_set;

  assign acc          = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr           = acc && wb_we_i;
  assign be_mask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign proc_en      = ctrl_r[BIT_PROC_EN];
  assign cold_support = ctrl_r[BIT_COLD_SUPPORT];
  assign override_set = wr && (wb_adr_i == ADDR_CMD) && wb_sel_i[0] && wb_dat_i[BIT_OVERRIDE];

  always_comb begin
    cmd_read                                     = 32'h0000_0000;
    cmd_read[BIT_PROC_EN]                        = ctrl_r[BIT_PROC_EN];
    cmd_read[BIT_POWER]                          = ctrl_r[BIT_POWER] | ~cold_support; // RQ14
    cmd_read[BIT_OVERRIDE]                       = ctrl_r[BIT_OVERRIDE];
    cmd_read[BIT_FRX_EN]                         = ctrl_r[BIT_FRX_EN];
    cmd_read[BIT_SLOT_LO +: 5]                   = current_command_slot_r; // RQ8
    cmd_read[BIT_SWITCH]                         = mech_switch_state_r; // RQ6
    cmd_read[BIT_FRX_RUN]                        = frame_receive_running_r; // RQ5
    cmd_read[BIT_CMD_RUN]                        = command_list_running_r; // RQ4
    cmd_read[BIT_COLD_STATE]                     = cold_presence_state_r; // RQ2
    cmd_read[BIT_PM_ATTACHED]                    = ctrl_r[BIT_PM_ATTACHED]; // RQ1
    cmd_read[BIT_HOT_PLUG]                       = ctrl_r[BIT_HOT_PLUG];
    cmd_read[BIT_SW_PRESENT]                     = ctrl_r[BIT_SW_PRESENT];
    cmd_read[BIT_COLD_SUPPORT]                   = ctrl_r[BIT_COLD_SUPPORT];
    cmd_read[BIT_SW_CAP]                         = switch_capability_i;
  end

  // Wishbone slave, ack registered one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_CMD:  wb_dat_o <= cmd_read; // RQ19
          ADDR_CI:   wb_dat_o <= command_issue_reg_r;
          ADDR_STAT: wb_dat_o <= {24'h00_0000, task_file_data_r};
          default:   wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable control bits; reserved and status bits masked out
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= CMD_RESET;
    end else begin
      if (wr && (wb_adr_i == ADDR_CMD)) begin
        ctrl_r[BIT_PROC_EN]      <= wb_sel_i[0] ? wb_dat_i[BIT_PROC_EN] : ctrl_r[BIT_PROC_EN];
        ctrl_r[BIT_FRX_EN]       <= wb_sel_i[0] ? wb_dat_i[BIT_FRX_EN] : ctrl_r[BIT_FRX_EN];
        if (wb_sel_i[0] && cold_support)
          ctrl_r[BIT_POWER]      <= wb_dat_i[BIT_POWER]; // RQ14
        if (wb_sel_i[2]) begin
          ctrl_r[BIT_PM_ATTACHED]  <= wb_dat_i[BIT_PM_ATTACHED];
          ctrl_r[BIT_HOT_PLUG]     <= wb_dat_i[BIT_HOT_PLUG];
          ctrl_r[BIT_SW_PRESENT]   <= wb_dat_i[BIT_SW_PRESENT];
          ctrl_r[BIT_COLD_SUPPORT] <= wb_dat_i[BIT_COLD_SUPPORT];
        end
      end
      // Override set by writing one, then drops once flags are clear
      if (override_set)
        ctrl_r[BIT_OVERRIDE] <= 1'b1; // RQ12
      else if (!task_file_data_r[BIT_TASK_BUSY] && !task_file_data_r[BIT_DATA_REQUEST])
        ctrl_r[BIT_OVERRIDE] <= 1'b0; // RQ12
    end
  end

  // Task file status: override clears busy and request; software may preset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      task_file_data_r <= TFD_RESET;
    end else if (override_set) begin
      task_file_data_r[BIT_TASK_BUSY]    <= 1'b0; // RQ12
      task_file_data_r[BIT_DATA_REQUEST] <= 1'b0; // RQ12
    end else if (wr && (wb_adr_i == ADDR_STAT) && wb_sel_i[0]) begin
      task_file_data_r <= wb_dat_i[7:0];
    end
  end

  // Cold presence: reset 0, seeded from input right after release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cold_presence_state_r <= 1'b0;
      cold_seeded_r         <= 1'b0;
    end else begin
      cold_seeded_r <= 1'b1;
      if (!cold_seeded_r || cold_support)
        cold_presence_state_r <= cold_presence_detect_in_i; // RQ2 RQ3
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      mech_switch_state_r <= 1'b0;
    else if (!switch_capability_i)
      mech_switch_state_r <= 1'b0; // RQ6
    else if (ctrl_r[BIT_SW_PRESENT])
      mech_switch_state_r <= mech_switch_in_i; // RQ6
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      device_power_out_o <= 1'b0;
    else
      device_power_out_o <= cmd_read[BIT_POWER]; // RQ15
  end

  // Receive path: post only when enabled, one first D2H frame allowed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_receive_running_r <= 1'b0;
      frame_post_o            <= 1'b0;
      frame_reject_o          <= 1'b0;
      first_d2h_done_r        <= 1'b0;
    end else begin
      frame_receive_running_r <= ctrl_r[BIT_FRX_EN]; // RQ5
      frame_post_o   <= frame_valid_i && ctrl_r[BIT_FRX_EN]; // RQ10
      frame_reject_o <= frame_valid_i && !ctrl_r[BIT_FRX_EN]
                        && !(frame_first_d2h_i && !first_d2h_done_r); // RQ10
      if (frame_valid_i && frame_first_d2h_i)
        first_d2h_done_r <= 1'b1;
    end
  end

  // Completion clears and software sets merge; a set wins on a clash
  always_comb begin
    ci_clr = 32'h0000_0000;
    ci_set = 32'h0000_0000;
    if (iss_r == ISS_WAIT && cmd_done_i)
      ci_clr[current_command_slot_r] = 1'b1;
    if (wr && (wb_adr_i == ADDR_CI))
      ci_set = wb_dat_i & be_mask;
  end

  slot_picker i_slot_picker (
    .pending_i (command_issue_reg_r),
    .start_i   (next_prio_r),
    .found_o   (found),
    .slot_o    (pick)
  );

  // Issue engine; software sets issue bits, completion clears, set wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      iss_r                  <= ISS_IDLE;
      proc_en_d_r            <= 1'b0;
      current_command_slot_r <= SLOT_RESET;
      next_prio_r            <= SLOT_RESET;
      command_issue_reg_r    <= 32'h0000_0000;
      issue_valid_o          <= 1'b0;
      issue_slot_o           <= SLOT_RESET;
      command_list_running_r <= 1'b0;
    end else begin
      proc_en_d_r            <= proc_en;
      command_list_running_r <= proc_en; // RQ4
      issue_valid_o          <= 1'b0;
      if (!proc_en) begin
        iss_r                  <= ISS_IDLE;
        current_command_slot_r <= SLOT_RESET; // RQ8
        next_prio_r            <= SLOT_RESET; // RQ9
        command_issue_reg_r    <= 32'h0000_0000;
      end else begin
        command_issue_reg_r <= (command_issue_reg_r & ~ci_clr) | ci_set;
        if (!proc_en_d_r)
          next_prio_r <= SLOT_RESET; // RQ18
        case (iss_r)
          ISS_IDLE: iss_r <= ISS_SCAN;
          ISS_SCAN: begin
            if (found && proc_en_d_r) begin
              current_command_slot_r <= pick; // RQ8
              issue_slot_o           <= pick;
              issue_valid_o          <= 1'b1;
              next_prio_r            <= pick + 5'h01; // RQ9
              iss_r                  <= ISS_WAIT;
            end
          end
          ISS_WAIT: if (cmd_done_i) iss_r <= ISS_SCAN;
          default:  iss_r <= ISS_IDLE;
        endcase
      end
    end
  end

  // Start, stop and issue order
  slot_zero_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ18
    $rose(proc_en) |=> next_prio_r == 5'h00)
    else $error("priority not slot zero after start");
  slot_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ8
    !proc_en |=> current_command_slot_r == 5'h00)
    else $error("slot not cleared when stopped");
  ci_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !proc_en |=> command_issue_reg_r == 32'h0000_0000)
    else $error("issue bits kept while stopped");
  prio_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ9
    issue_valid_o |-> next_prio_r == issue_slot_o + 5'h01)
    else $error("priority not slot plus one");
  slot_track_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ8
    issue_valid_o |-> current_command_slot_r == issue_slot_o)
    else $error("slot field not issued slot");
  issue_gap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    issue_valid_o |=> !issue_valid_o)
    else $error("issue pulse too long");
  iss_onehot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $onehot(iss_r))
    else $error("issue state not one-hot");
  run_flags_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ4
    ##1 command_list_running_r == $past(proc_en))
    else $error("running flag wrong");
  frx_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ5
    $past(rst_b_i) |-> frame_receive_running_r == $past(ctrl_r[BIT_FRX_EN]))
    else $error("receive running flag wrong");

  // Control bits, pins and frames
  power_pin_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ15
    $past(rst_b_i) |-> device_power_out_o == $past(cmd_read[BIT_POWER]))
    else $error("power pin mismatch");
  power_fixed_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ14
    !cold_support |-> cmd_read[BIT_POWER])
    else $error("power bit not one");
  power_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ14
    !cold_support |=> $stable(ctrl_r[BIT_POWER]))
    else $error("power bit written without support");
  switch_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ6
    !switch_capability_i |=> !mech_switch_state_r)
    else $error("switch bit not zero");
  switch_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ6
    switch_capability_i && ctrl_r[BIT_SW_PRESENT]
    |=> mech_switch_state_r == $past(mech_switch_in_i))
    else $error("switch state not followed");
  cold_mirror_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ2
    cold_support && cold_seeded_r |=> cold_presence_state_r == $past(cold_presence_detect_in_i))
    else $error("cold state not mirrored");
  cold_seed_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ3
    rst_b_i && !cold_seeded_r |=> cold_presence_state_r == $past(cold_presence_detect_in_i))
    else $error("cold state not seeded");
  override_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ12
    override_set |=> !task_file_data_r[BIT_TASK_BUSY] && !task_file_data_r[BIT_DATA_REQUEST])
    else $error("busy or request not cleared");
  override_drop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ12
    ctrl_r[BIT_OVERRIDE] && !override_set && !task_file_data_r[BIT_TASK_BUSY]
    && !task_file_data_r[BIT_DATA_REQUEST] |=> !ctrl_r[BIT_OVERRIDE])
    else $error("override not self-cleared");
  reject_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
    frame_post_o |-> $past(ctrl_r[BIT_FRX_EN]))
    else $error("frame posted while disabled");
  reject_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
    frame_reject_o |-> !$past(ctrl_r[BIT_FRX_EN]))
    else $error("frame refused while enabled");
  first_d2h_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
    frame_reject_o |-> !$past(frame_first_d2h_i && !first_d2h_done_r))
    else $error("first register frame refused");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ19
    cmd_read[7:5] == 3'h0)
    else $error("reserved bits not zero");
endmodule : sata_port_command_control

// [src/port_cmd_pkg.sv]
// Contract
// RQ1: Software sets multiplier flag; no auto-detect
// RQ2: Bit 16 mirrors cold presence input; the code mirrors it only while cold support is set or in the first cycle after reset, else holds it
// RQ3: Presence bit may reset to input level
// RQ4: Bit 15 shows command engine running
// RQ5: Bit 14 shows receive engine running
// RQ6: Bit 13 shows switch; zero without capability
// RQ7: Software trusts switch bit only when enabled
// RQ8: Slot field tracks issued slot, clears
// RQ9: Priority starts slot 0, then current plus one
// RQ10: Receive enable gates frame posting
// RQ11: Software sets base before receive enable
// RQ12: Override clears busy/request, self-clears
// RQ13: Software sets override just before start
// RQ14: Power bit writable only with cold support
// RQ15: Power bit drives device power pin
// RQ16: Software sets cold support with hot-plug
// RQ17: Software sets switch-present with hot-plug
// RQ18: Start processes list from entry zero
// RQ19: Reserved bits 7-5 read zero
package port_cmd_pkg;
  localparam logic [3:0]  ADDR_CMD         = 4'h0;
  localparam logic [3:0]  ADDR_CI          = 4'h4;
  localparam logic [3:0]  ADDR_STAT        = 4'h8;
  localparam int          BIT_PROC_EN      = 0;
  localparam int          BIT_POWER        = 2;
  localparam int          BIT_OVERRIDE     = 3;
  localparam int          BIT_FRX_EN       = 4;
  localparam int          BIT_SLOT_LO      = 8;
  localparam int          BIT_SWITCH       = 13;
  localparam int          BIT_FRX_RUN      = 14;
  localparam int          BIT_CMD_RUN      = 15;
  localparam int          BIT_COLD_STATE   = 16;
  localparam int          BIT_PM_ATTACHED  = 17;
  localparam int          BIT_HOT_PLUG     = 18;
  localparam int          BIT_SW_PRESENT   = 19;
  localparam int          BIT_COLD_SUPPORT = 20;
  localparam int          BIT_SW_CAP       = 21;
  localparam logic [31:0] CMD_RESET        = 32'h0000_0004;
  localparam logic [31:0] CMD_WR_MASK      = 32'h001E_0015;
  localparam logic [4:0]  SLOT_RESET       = 5'h00;
  localparam logic [7:0]  TFD_RESET        = 8'h7F;
  localparam int          BIT_TASK_BUSY    = 7;
  localparam int          BIT_DATA_REQUEST = 3;
  typedef enum logic [2:0] {
    ISS_IDLE = 3'b001,
    ISS_SCAN = 3'b010,
    ISS_WAIT = 3'b100
  } issue_state_t;
endpackage : port_cmd_pkg

// [src/slot_picker.sv]
`timescale 1ns/1ps
// Rotating priority search over the issue vector
module slot_picker
  import port_cmd_pkg::*;
(
  input  wire logic [31:0] pending_i,
  input  wire logic [4:0]  start_i,
  output logic             found_o,
  output logic [4:0]       slot_o
);
  always_comb begin
    logic [4:0] idx;
    idx     = 5'h00;
    found_o = 1'b0;
    slot_o  = 5'h00;
    for (int k = 31; k >= 0; k--) begin
      idx = start_i + k[4:0];
      if (pending_i[idx]) begin
        found_o = 1'b1;
        slot_o  = idx;
      end
    end
  end
endmodule : slot_picker

// [test/sata_port_command_control_test.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sata_port_command_control_test
  import port_cmd_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        cold_i = 1'b0;
  logic        sw_i = 1'b0;
  logic        cap_i = 1'b1;
  logic        cmd_done_i = 1'b0;
  logic        frame_valid_i = 1'b0;
  logic        frame_first_d2h_i = 1'b0;
  logic        frame_post_o;
  logic        frame_reject_o;
  logic        issue_valid_o;
  logic [4:0]  issue_slot_o;
  logic        device_power_out_o;
  logic [31:0] rd_q[$];
  logic [4:0]  iq[$];
  logic [1:0]  fq[$];
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_iss = 0;
  logic [31:0] seed = 32'hE5BB857E;
  logic [31:0] r;

  sata_port_command_control i_sata_port_command_control (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cold_presence_detect_in_i(cold_i),
    .mech_switch_in_i(sw_i), .switch_capability_i(cap_i), .cmd_done_i(cmd_done_i),
    .frame_valid_i(frame_valid_i), .frame_first_d2h_i(frame_first_d2h_i),
    .frame_post_o(frame_post_o), .frame_reject_o(frame_reject_o),
    .issue_valid_o(issue_valid_o), .issue_slot_o(issue_slot_o),
    .device_power_out_o(device_power_out_o));

  always #4 clk_i = ~clk_i;

  // Watcher: every result is matched against the oldest note
  always @(posedge clk_i) begin : watch
    logic [31:0] e;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      e = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hDEAD_BEEF;
      `CHK(wb_dat_o, e)
    end
    if (issue_valid_o === 1'b1) begin
      n_iss++;
      e = (iq.size() > 0) ? {27'h0, iq.pop_front()} : 32'hFF;
      `CHK({27'h0, issue_slot_o}, e)
    end
    if ((frame_post_o | frame_reject_o) === 1'b1) begin
      e = (fq.size() > 0) ? {30'h0, fq.pop_front()} : 32'hFF;
      `CHK({30'h0, frame_post_o, frame_reject_o}, e)
    end
  end

  task end_sim;
    if (rd_q.size() + iq.size() + fq.size() != 0) n_mismatch++;
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin n_mismatch++; end_sim(); end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // Waits for the n-th issue overall, then optionally completes it
  task wait_iss(input int n, input bit done);
    int k;
    k = 0;
    while (n_iss < n && k < 50) begin @(posedge clk_i); k++; end
    if (k >= 50) begin n_mismatch++; end_sim(); end
    if (done) begin
      cmd_done_i <= 1'b1;
      @(posedge clk_i);
      cmd_done_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask : wait_iss

  task frame(input logic first, input logic [1:0] e);
    if (e != 2'b00) fq.push_back(e);
    frame_first_d2h_i <= first;
    frame_valid_i     <= 1'b1;
    @(posedge clk_i);
    frame_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : frame

  task do_reset;
    rst_b_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  initial begin
    do_reset();
    rd(ADDR_CMD, 32'h0020_0004);
    rd(ADDR_STAT, 32'h0000_007F);
    rd(4'hC, 32'h0);
    r = {31'h0, 1'($random(seed))};
    wb(1'b1, ADDR_CMD, (r << 17) | 32'h0000_00E0);
    rd(ADDR_CMD, 32'h0020_0004 | (r << 17));
    `CHK(device_power_out_o, 1'b1)
    wb(1'b1, ADDR_CMD, 32'h0014_0000);
    cold_i <= 1'b1;
    wb(1'b1, ADDR_CMD, 32'h0014_0000);
    rd(ADDR_CMD, 32'h0035_0000);
    `CHK(device_power_out_o, 1'b0)
    cold_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_CMD, 32'h0034_0000);
    r = {31'h0, 1'($random(seed))};
    sw_i <= r[0];
    wb(1'b1, ADDR_CMD, 32'h001C_0004);
    rd(ADDR_CMD, 32'h003C_0004 | (r << 13));
    `CHK(device_power_out_o, 1'b1)
    cap_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_CMD, 32'h001C_0004);
    cap_i <= 1'b1;
    wb(1'b1, ADDR_CMD, 32'h0);
    frame(1'b0, 2'b01);
    frame(1'b1, 2'b00);
    wb(1'b1, ADDR_CMD, 32'h10);
    frame(1'b0, 2'b10);
    wb(1'b1, ADDR_STAT, 32'hFF);
    rd(ADDR_STAT, 32'hFF);
    wb(1'b1, ADDR_CMD, 32'h18);
    wb(1'b1, ADDR_CMD, 32'h11);
    rd(ADDR_STAT, 32'h77);
    rd(ADDR_CMD, 32'h0020_C015);
    iq = '{5'd0, 5'd1, 5'd31, 5'd0, 5'd1, 5'd5};
    wb(1'b1, ADDR_CI, 32'h3);
    wait_iss(1, 1'b1);
    wait_iss(2, 1'b1);
    wb(1'b1, ADDR_CI, 32'h8000_0001);
    wait_iss(3, 1'b1);
    wait_iss(4, 1'b1);
    wb(1'b1, ADDR_CI, 32'h22);
    wait_iss(5, 1'b1);
    wait_iss(6, 1'b0);
    rd(ADDR_CMD, 32'h0020_C515);
    // Stop with slot 5 in flight; restart must not resume from 6
    wb(1'b1, ADDR_CMD, 32'h0);
    rd(ADDR_CMD, 32'h0020_0004);
    wb(1'b1, ADDR_CMD, 32'h1);
    iq.push_back(5'd0);
    iq.push_back(5'd6);
    wb(1'b1, ADDR_CI, 32'h41);
    wait_iss(7, 1'b1);
    wait_iss(8, 1'b0);
    cold_i <= 1'b1;
    do_reset();
    rd(ADDR_CMD, 32'h0021_0004);
    end_sim();
  end
endmodule : sata_port_command_control_test
